// ===== pkg/sbt_pkg.sv
// constants for the sixteen-bit up timer
package sbt_pkg;
  localparam logic [7:0] SBT_MODE_ADDR = 8'h06;
  localparam logic [7:0] SBT_EDGE_ADDR = 8'h0c;
  localparam logic [7:0] SBT_MODE_RST = 8'h00;
  localparam logic [7:0] SBT_EDGE_RST = 8'h00;
  localparam int SBT_CLK_HI = 7;
  localparam int SBT_CLK_LO = 5;
  localparam int SBT_PRE_HI = 4;
  localparam int SBT_PRE_LO = 3;
  localparam int SBT_TAP_HI = 2;
  localparam int SBT_TAP_LO = 0;
  localparam int SBT_EDGE_BIT = 5;
  localparam int SBT_TAP_BASE = 8;
  localparam logic [2:0] SBT_SRC_STOP = 3'h0;
  localparam logic [2:0] SBT_SRC_SYS = 3'h1;
  localparam logic [2:0] SBT_SRC_UNUSED = 3'h2;
  localparam logic [2:0] SBT_SRC_PIN_A4 = 3'h3;
  localparam logic [2:0] SBT_SRC_FAST = 3'h4;
  localparam logic [2:0] SBT_SRC_XTAL = 3'h5;
  localparam logic [2:0] SBT_SRC_SLOW = 3'h6;
  localparam logic [2:0] SBT_SRC_PIN_A0 = 3'h7;
  localparam logic [1:0] SBT_DIV_1 = 2'h0;
  localparam logic [1:0] SBT_DIV_4 = 2'h1;
  localparam logic [1:0] SBT_DIV_16 = 2'h2;
  localparam logic [1:0] SBT_DIV_64 = 2'h3;
  localparam logic [5:0] SBT_PRE_MASK_1 = 6'h00;
  localparam logic [5:0] SBT_PRE_MASK_4 = 6'h03;
  localparam logic [5:0] SBT_PRE_MASK_16 = 6'h0f;
  localparam logic [5:0] SBT_PRE_MASK_64 = 6'h3f;
  localparam logic [15:0] SBT_CNT_RST = 16'h0000;
  localparam logic [15:0] SBT_CNT_ONE = 16'h0001;
  localparam logic [5:0] SBT_PRE_ONE = 6'h01;
  localparam logic [5:0] SBT_PRE_ZERO = 6'h00;
endpackage

// ===== rtl/sbt_edge_sync.sv
// two-flop synchroniser with rising edge pulse
`timescale 1ns/1ns
`default_nettype none
module sbt_edge_sync (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic rise_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_out = sync_q & ~prev_q;
endmodule
`default_nettype wire

// ===== rtl/sbt_timer.sv
// sixteen-bit up timer with clock select, prescaler and tap interrupt
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (R1) mode bits 7..5 pick stop, system, unused, pin a4, fast osc, crystal, slow osc or pin a0 as timer clock.
// (R2) the stop selection holds the counter without counting.
// (R3) mode bits 4..3 divide the selected clock by 1, 4, 16 or 64 before the counter.
// (R4) the 16-bit counter increments by one per prescaled tick; a store in the same cycle takes priority.
// (R5) the store instruction loads a 16-bit start value into the counter.
// (R6) the load instruction returns the current 16-bit counter value.
// (R7) mode bits 2..0 pick counter bit 8 to 15 as interrupt source.
// (R8) edge register bit 5 picks rising or falling transition of that bit.
// (R9) overflow with bit 15 selected triggers the interrupt when edge bit 5 is set (falling).
// (R10) a timer event sets bit 2 of the interrupt request flags.
// (R11) free running gives one event per 2 to the n+9 prescaled ticks.
// (R12) with edge bit clear a zero to one transition sets the flag.
// (R13) software clears the flag by writing zero; it stays set until then.
// (R14) pin clock sources are synchronised and each rising edge is one input clock.
module sbt_timer (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic counter_store_instr_in,
  input wire logic [15:0] store_data_in,
  input wire logic counter_load_instr_in,
  input wire logic fast_internal_osc_tick_in,
  input wire logic crystal_osc_tick_in,
  input wire logic slow_internal_osc_tick_in,
  input wire logic pin_a_four_clock_in,
  input wire logic pin_a_zero_clock_in,
  input wire logic irq_flag_clr_in,
  output logic [7:0] mode_rdata_out,
  output logic [7:0] edge_rdata_out,
  output logic [15:0] load_data_out,
  output logic load_valid_out,
  output logic [15:0] count_out,
  output logic irq_flag_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] mode_q;
  logic [7:0] edge_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [5:0] pre_q;
  logic [5:0] pre_mask;
  logic src_tick;
  logic pre_tick;
  logic tap_q;
  logic tap_now;
  logic tap_prev_q;
  logic event_hit;
  logic flag_q;
  logic [15:0] load_q;
  logic load_v_q;
  logic a4_rise;
  logic a0_rise;
  logic [2:0] src_sel;
  logic [1:0] div_sel;
  logic [2:0] tap_sel;
  logic mode_wr;
  logic edge_wr;
  logic pre_wrap;
  logic tap_rise;
  logic tap_fall;

  assign src_sel = mode_q[sbt_pkg::SBT_CLK_HI:sbt_pkg::SBT_CLK_LO];
  assign div_sel = mode_q[sbt_pkg::SBT_PRE_HI:sbt_pkg::SBT_PRE_LO];
  assign tap_sel = mode_q[sbt_pkg::SBT_TAP_HI:sbt_pkg::SBT_TAP_LO];

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign mode_wr = io_wr_in && (io_addr_in == sbt_pkg::SBT_MODE_ADDR);
  assign edge_wr = io_wr_in && (io_addr_in == sbt_pkg::SBT_EDGE_ADDR);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mode_q <= sbt_pkg::SBT_MODE_RST;
    end
    else if (mode_wr)
    begin
      mode_q <= io_wdata_in; // R1 R3 R7
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      edge_q <= sbt_pkg::SBT_EDGE_RST;
    end
    else if (edge_wr)
    begin
      edge_q <= io_wdata_in; // R8
    end
  end

  // ----------------------------------------
  // pin clock synchronisers
  // ----------------------------------------
  sbt_edge_sync u_sync_a4 (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(pin_a_four_clock_in),
    .rise_out(a4_rise)
  ); // R14

  sbt_edge_sync u_sync_a0 (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(pin_a_zero_clock_in),
    .rise_out(a0_rise)
  ); // R14

  // ----------------------------------------
  // source select and prescaler
  // ----------------------------------------
  always_comb
  begin
    case (src_sel) // R1
      sbt_pkg::SBT_SRC_STOP: src_tick = 1'b0; // R2
      sbt_pkg::SBT_SRC_SYS: src_tick = 1'b1;
      sbt_pkg::SBT_SRC_UNUSED: src_tick = 1'b0;
      sbt_pkg::SBT_SRC_PIN_A4: src_tick = a4_rise;
      sbt_pkg::SBT_SRC_FAST: src_tick = fast_internal_osc_tick_in;
      sbt_pkg::SBT_SRC_XTAL: src_tick = crystal_osc_tick_in;
      sbt_pkg::SBT_SRC_SLOW: src_tick = slow_internal_osc_tick_in;
      sbt_pkg::SBT_SRC_PIN_A0: src_tick = a0_rise;
      default: src_tick = 1'b0;
    endcase
  end

  always_comb
  begin
    case (div_sel) // R3
      sbt_pkg::SBT_DIV_1: pre_mask = sbt_pkg::SBT_PRE_MASK_1;
      sbt_pkg::SBT_DIV_4: pre_mask = sbt_pkg::SBT_PRE_MASK_4;
      sbt_pkg::SBT_DIV_16: pre_mask = sbt_pkg::SBT_PRE_MASK_16;
      sbt_pkg::SBT_DIV_64: pre_mask = sbt_pkg::SBT_PRE_MASK_64;
      default: pre_mask = sbt_pkg::SBT_PRE_MASK_1;
    endcase
  end

  assign pre_wrap = ((pre_q & pre_mask) == pre_mask);
  assign pre_tick = src_tick && pre_wrap; // R3

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pre_q <= sbt_pkg::SBT_PRE_ZERO;
    end
    else if (src_tick)
    begin
      pre_q <= (pre_tick) ? sbt_pkg::SBT_PRE_ZERO : pre_q + sbt_pkg::SBT_PRE_ONE;
    end
  end

  // ----------------------------------------
  // counter, store and load
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (counter_store_instr_in)
    begin
      cnt_d = store_data_in; // R5
    end
    else if (pre_tick)
    begin
      cnt_d = cnt_q + sbt_pkg::SBT_CNT_ONE; // R4 R9
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= sbt_pkg::SBT_CNT_RST;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      load_v_q <= 1'b0;
    end
    else
    begin
      load_v_q <= counter_load_instr_in; // R6
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      load_q <= sbt_pkg::SBT_CNT_RST;
    end
    else if (counter_load_instr_in)
    begin
      load_q <= cnt_q; // R6
    end
  end

  // ----------------------------------------
  // tap edge detect and request flag
  // ----------------------------------------
  assign tap_now = cnt_q[sbt_pkg::SBT_TAP_BASE + int'(tap_sel)]; // R7 R11

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tap_prev_q <= 1'b0;
    end
    else
    begin
      tap_prev_q <= tap_now;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tap_q <= 1'b0;
    end
    else
    begin
      tap_q <= tap_prev_q;
    end
  end

  assign tap_rise = ~tap_q & tap_prev_q;
  assign tap_fall = tap_q & ~tap_prev_q;

  // edge bit clear: rising, set: falling
  assign event_hit = edge_q[sbt_pkg::SBT_EDGE_BIT] ? tap_fall : tap_rise; // R8 R12

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      flag_q <= 1'b0;
    end
    else if (event_hit)
    begin
      flag_q <= 1'b1; // R10
    end
    else if (irq_flag_clr_in)
    begin
      flag_q <= 1'b0; // R13
    end
  end

  // ----------------------------------------
  // readback and status outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mode_rdata_out <= sbt_pkg::SBT_MODE_RST;
    end
    else
    begin
      mode_rdata_out <= mode_q;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      edge_rdata_out <= sbt_pkg::SBT_EDGE_RST;
    end
    else
    begin
      edge_rdata_out <= edge_q;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      count_out <= sbt_pkg::SBT_CNT_RST;
    end
    else
    begin
      count_out <= cnt_q;
    end
  end

  assign load_data_out = load_q;
  assign load_valid_out = load_v_q;
  assign irq_flag_out = flag_q;
endmodule
`default_nettype wire

// ===== verif/sbt_timer_sva.sv
// assertion checker for the sixteen-bit up timer
`timescale 1ns/1ns
`default_nettype none
module sbt_timer_sva (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic counter_store_instr_in,
  input wire logic [15:0] store_data_in,
  input wire logic counter_load_instr_in,
  input wire logic irq_flag_clr_in,
  input wire logic [7:0] mode_rdata_out,
  input wire logic [7:0] edge_rdata_out,
  input wire logic [15:0] load_data_out,
  input wire logic load_valid_out,
  input wire logic [15:0] count_out,
  input wire logic irq_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // selected tap bit, flipped for falling edge mode
  wire logic tap = count_out[8 + mode_rdata_out[2:0]] ^ edge_rdata_out[5];
  // ----
  // properties
  // ----
  mode_write_a:
  assert property (io_wr_in && io_addr_in == 8'h06 |-> ##2 mode_rdata_out == $past(io_wdata_in, 2))
    else $error("mode readback wrong");
  edge_write_a:
  assert property (io_wr_in && io_addr_in == 8'h0c |-> ##2 edge_rdata_out == $past(io_wdata_in, 2))
    else $error("edge readback wrong");
  stop_hold_a:
  assert property (mode_rdata_out[7:5] == 3'h0 && !$past(counter_store_instr_in) |=> $stable(count_out))
    else $error("counter moved while stopped");
  count_step_a:
  assert property ($changed(count_out) && !$past(counter_store_instr_in, 2) |-> count_out == $past(count_out) + 16'h0001)
    else $error("counter step not plus one");
  store_load_a:
  assert property (counter_store_instr_in |-> ##2 count_out == $past(store_data_in, 2))
    else $error("store value not loaded");
  load_copy_a:
  assert property (counter_load_instr_in |=> load_valid_out && load_data_out == count_out)
    else $error("load value wrong");
  load_pulse_a:
  assert property (!counter_load_instr_in |=> !load_valid_out)
    else $error("load valid without request");
  tap_event_a:
  assert property ($rose(tap) && $stable(mode_rdata_out) && $stable(edge_rdata_out)
    && !$past(counter_store_instr_in, 2) ##1 $stable(edge_rdata_out) |-> irq_flag_out)
    else $error("tap edge did not set flag");
  flag_hold_a:
  assert property (irq_flag_out && !irq_flag_clr_in |=> irq_flag_out)
    else $error("flag dropped without clear");
  cover property ($rose(irq_flag_out));
  cover property (load_valid_out);
  cover property ($fell(count_out[15]));
endmodule
bind sbt_timer sbt_timer_sva u_sva (.*);
`default_nettype wire

// ===== verif/sbt_timer_tb.sv
// self-checking bench for the sixteen-bit up timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("Error %s exp %0h got %0h", n, e, s); end end
module sbt_timer_tb;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic io_wr_in = 1'b0;
  logic counter_store_instr_in = 1'b0;
  logic counter_load_instr_in = 1'b0;
  logic irq_flag_clr_in = 1'b0;
  logic [7:0] io_addr_in = 8'h00;
  logic [7:0] io_wdata_in = 8'h00;
  logic [15:0] store_data_in = 16'h0000;
  logic [7:0] cyc = 8'h00;
  logic [7:0] mode_rdata_out;
  logic [7:0] edge_rdata_out;
  logic [15:0] load_data_out;
  logic [15:0] count_out;
  logic [15:0] a;
  logic load_valid_out;
  logic irq_flag_out;
  // oscillator ticks and pin clocks, pin a4 at the slow oscillator rate
  wire logic fast_internal_osc_tick_in = cyc[0];
  wire logic crystal_osc_tick_in = (cyc[1:0] == 2'h0);
  wire logic slow_internal_osc_tick_in = (cyc[2:0] == 3'h0);
  wire logic pin_a_four_clock_in = cyc[2];
  wire logic pin_a_zero_clock_in = cyc[3];
  int n_fail = 0;
  int n_tests = 0;
  int n;
  logic [7:0] modes [11] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'h28, 8'h30, 8'h38};
  logic [15:0] rate [11] = '{16'h0000, 16'h0080, 16'h0000, 16'h0010, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
    16'h0020, 16'h0008, 16'h0002};
  sbt_timer dut (.*);
  always #5 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) cyc <= cyc + 8'h01;
  // ----
  // access tasks
  // ----
  task automatic end_sim();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    io_wr_in = 1'b1;
    io_addr_in = ad;
    io_wdata_in = d;
    @(negedge ref_clk_in);
    io_wr_in = 1'b0;
    @(negedge ref_clk_in);
  endtask
  task automatic st(input logic [15:0] d);
    counter_store_instr_in = 1'b1;
    store_data_in = d;
    @(negedge ref_clk_in);
    counter_store_instr_in = 1'b0;
  endtask
  task automatic clr();
    irq_flag_clr_in = 1'b1;
    @(negedge ref_clk_in);
    irq_flag_clr_in = 1'b0;
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq_flag_out !== 1'b1)
    begin
      @(negedge ref_clk_in);
      n++;
      if (n > 2000)
      begin
        n_fail++;
        end_sim();
      end
    end
  endtask
  initial
  begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    `CHK("count", 16'h0000, count_out)
    wr(8'h0c, 8'h20);
    wr(8'h07, 8'hff);
    `CHK("edge", 8'h20, edge_rdata_out)
    `CHK("mode", 8'h00, mode_rdata_out)
    wr(8'h0c, 8'h00);
    st(16'h1234);
    repeat (20) @(negedge ref_clk_in);
    counter_load_instr_in = 1'b1;
    @(negedge ref_clk_in);
    `CHK("load", 16'h1234, load_data_out)
    `CHK("load valid", 1'b1, load_valid_out)
    counter_load_instr_in = 1'b0;
    @(negedge ref_clk_in);
    `CHK("load valid", 1'b0, load_valid_out)
    $display("done: stop store load");
    for (int i = 0; i < 11; i++)
    begin
      wr(8'h06, modes[i]);
      `CHK("mode", modes[i], mode_rdata_out)
      repeat (6) @(negedge ref_clk_in);
      a = count_out;
      repeat (128) @(negedge ref_clk_in);
      `CHK("rate", rate[i], count_out - a)
    end
    $display("done: sources and dividers");
    wr(8'h06, 8'h00);
    st(16'h00f0);
    clr();
    wr(8'h06, 8'h20);
    wait_irq();
    repeat (10) @(negedge ref_clk_in);
    `CHK("hold", 1'b1, irq_flag_out)
    clr();
    `CHK("clear", 1'b0, irq_flag_out)
    wait_irq();
    `CHK("period", 512, n + 11)
    wr(8'h06, 8'h00);
    st(16'hfff0);
    wr(8'h0c, 8'h20);
    repeat (4) @(negedge ref_clk_in);
    clr();
    wr(8'h06, 8'h27);
    wait_irq();
    `CHK("wrap", 1'b1, n > 14 && n < 30)
    $display("done: interrupts");
    end_sim();
  end
endmodule
`default_nettype wire
